// file: pkg/esr_pkg.sv
`default_nettype none
package esr_pkg;
	localparam logic [11:0] ESR_INT_STATE_OFF = 12'hd04;
	localparam logic [11:0] ESR_APP_CTRL_OFF = 12'hd0c;
	localparam logic [11:0] ESR_IRQ_STAT_OFF = 12'hd40;
	localparam logic [11:0] ESR_IRQ_CLR_OFF = 12'hd44;
	localparam logic [11:0] ESR_IRQ_EN_OFF = 12'hd48;
	localparam int ESR_TPEND_SET_BIT = 26;
	localparam int ESR_TPEND_CLR_BIT = 25;
	localparam int ESR_PREEMPT_BIT = 23;
	localparam int ESR_IRQPEND_BIT = 22;
	localparam int ESR_HPEND_LSB = 12;
	localparam int ESR_ACTIVE_LSB = 0;
	localparam int ESR_KEY_LSB = 16;
	localparam int ESR_RSTREQ_BIT = 2;
	localparam int ESR_DBGCLR_BIT = 1;
	localparam logic [15:0] ESR_KEY_WRITE = 16'h05fa;
	localparam logic [15:0] ESR_KEY_READ = 16'hfa05;
	localparam logic [31:0] ESR_APP_CTRL_RST = 32'hfa050000;
	localparam logic [2:0] ESR_IRQ_RST = 3'h0;
	localparam int ESR_EV_PEND_SET = 0;
	localparam int ESR_EV_PEND_CLR = 1;
	localparam int ESR_EV_RST_REQ = 2;
endpackage
`default_nettype wire

// file: design/esr_ctrl.sv
// Overview of operation
// - Writing 1 to the timer set-pending bit makes the timer exception pending; 0 does nothing.
// - Reading the timer set-pending bit shows whether the timer exception is pending.
// - Writing 1 to the timer clear-pending bit removes the timer pending state unless set-pending or a timer event is also asserted; 0 does nothing.
// - A read-only bit shows that a pending exception will be taken on leaving debug halt.
// - A read-only flag shows any pending interrupt, not counting NMI and faults.
// - A read-only nine-bit field shows the highest-priority pending enabled exception, or zero.
// - A read-only nine-bit field shows the active exception number, zero in thread mode.
// - A control register write is ignored unless its upper half carries the access key.
// - The key field reads as a fixed constant.
// - A keyed write of 1 to the reset request bit raises a chip reset request.
// - The reset request bit is write-only and clears during the resulting reset.
`timescale 1ns/10ps
`default_nettype none
module esr_ctrl (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_timer_event,
	input wire logic i_timer_taken,
	input wire logic i_preempt_on_halt_exit,
	input wire logic i_irq_pending_flag,
	input wire logic [8:0] i_highest_pending_number,
	input wire logic [8:0] i_active_exception_number,
	output logic o_timer_pending,
	output logic o_chip_reset_request,
	output logic o_irq
);
	import esr_pkg::*;

	// ----------------------------------------------------------------
	// Write decode.
	// ----------------------------------------------------------------
	logic int_state_wr;
	logic app_ctrl_keyed_wr;
	logic irq_clr_wr;
	logic irq_en_wr;
	logic set_req;
	logic clr_req;
	logic rst_req;

	assign int_state_wr = i_wr && (i_addr == ESR_INT_STATE_OFF);
	assign app_ctrl_keyed_wr = i_wr && (i_addr == ESR_APP_CTRL_OFF) &&
		(i_wdata[ESR_KEY_LSB +: 16] == ESR_KEY_WRITE);
	assign irq_clr_wr = i_wr && (i_addr == ESR_IRQ_CLR_OFF);
	assign irq_en_wr = i_wr && (i_addr == ESR_IRQ_EN_OFF);
	assign set_req = int_state_wr && i_wdata[ESR_TPEND_SET_BIT];
	assign clr_req = int_state_wr && i_wdata[ESR_TPEND_CLR_BIT];
	assign rst_req = app_ctrl_keyed_wr && i_wdata[ESR_RSTREQ_BIT];

	// ----------------------------------------------------------------
	// Timer pending state.
	// ----------------------------------------------------------------
	logic timer_pend_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			timer_pend_q <= 1'b0;
		end else if (set_req || i_timer_event) begin
			timer_pend_q <= 1'b1;
		end else if (clr_req || i_timer_taken) begin
			timer_pend_q <= 1'b0;
		end
	end

	assign o_timer_pending = timer_pend_q;

	// ----------------------------------------------------------------
	// Chip reset request.
	// ----------------------------------------------------------------
	logic rst_req_q;

	// The request holds until the chip reset it causes clears this register.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_req_q <= 1'b0;
		end else if (rst_req) begin
			rst_req_q <= 1'b1;
		end
	end

	assign o_chip_reset_request = rst_req_q;

	// ----------------------------------------------------------------
	// Event status, clear and enable.
	// ----------------------------------------------------------------
	logic [2:0] ev_stat_q;
	logic [2:0] ev_en_q;
	logic [2:0] ev_set;

	assign ev_set[ESR_EV_PEND_SET] = set_req || i_timer_event;
	assign ev_set[ESR_EV_PEND_CLR] = clr_req;
	assign ev_set[ESR_EV_RST_REQ] = rst_req;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ev
			always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					ev_stat_q[g] <= 1'b0;
				end else if (ev_set[g]) begin
					ev_stat_q[g] <= 1'b1;
				end else if (irq_clr_wr && i_wdata[g]) begin
					ev_stat_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ev_en_q <= ESR_IRQ_RST;
		end else if (irq_en_wr) begin
			ev_en_q <= i_wdata[2:0];
		end
	end

	assign o_irq = |(ev_stat_q & ev_en_q);

	// ----------------------------------------------------------------
	// Read data.
	// ----------------------------------------------------------------
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h0;
		unique case (i_addr)
			ESR_INT_STATE_OFF: begin
				rdata_d[ESR_TPEND_SET_BIT] = timer_pend_q;
				rdata_d[ESR_PREEMPT_BIT] = i_preempt_on_halt_exit;
				rdata_d[ESR_IRQPEND_BIT] = i_irq_pending_flag;
				rdata_d[ESR_HPEND_LSB +: 9] = i_highest_pending_number;
				rdata_d[ESR_ACTIVE_LSB +: 9] = i_active_exception_number;
			end
			ESR_APP_CTRL_OFF: begin
				rdata_d[ESR_KEY_LSB +: 16] = ESR_KEY_READ;
			end
			ESR_IRQ_STAT_OFF: begin
				rdata_d[2:0] = ev_stat_q;
			end
			ESR_IRQ_EN_OFF: begin
				rdata_d[2:0] = ev_en_q;
			end
			default: begin
				rdata_d = 32'h0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= 32'h0;
		end
	end
endmodule // esr_ctrl
`default_nettype wire

// file: verif/esr_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module esr_ctrl_assertions (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_timer_event,
	input wire logic i_timer_taken,
	input wire logic i_preempt_on_halt_exit,
	input wire logic i_irq_pending_flag,
	input wire logic o_timer_pending,
	input wire logic o_chip_reset_request,
	input wire logic o_irq,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [31:0] o_rdata,
	input wire logic [8:0] i_highest_pending_number,
	input wire logic [8:0] i_active_exception_number
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wire w4 = i_wr && i_addr == 12'hd04;
	wire r4 = i_rd && i_addr == 12'hd04;
	wire kw = i_wr && i_addr == 12'hd0c && i_wdata[31:16] == 16'h05fa && i_wdata[2];
	property p_set; w4 && i_wdata[26] |=> o_timer_pending; endproperty
	a_set: assert property (p_set) else $error("set");
	property p_clr; w4 && i_wdata[26:25] == 2'b01 && !i_timer_event |=> !o_timer_pending; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_hi; r4 |=> o_rdata[31:21] == {5'h0, $past(o_timer_pending), 2'b0,
		$past(i_preempt_on_halt_exit), $past(i_irq_pending_flag), 1'b0}; endproperty
	a_hi: assert property (p_hi) else $error("hi");
	property p_lo; r4 |=> o_rdata[20:0] == {$past(i_highest_pending_number), 3'h0, $past(i_active_exception_number)}; endproperty
	a_lo: assert property (p_lo) else $error("lo");
	property p_key; i_rd && i_addr == 12'hd0c |=> o_rdata == 32'hfa050000; endproperty
	a_key: assert property (p_key) else $error("key");
	property p_req; kw |=> o_chip_reset_request; endproperty
	a_req: assert property (p_req) else $error("req");
	property p_nokey; !o_chip_reset_request && !kw |=> !o_chip_reset_request; endproperty
	a_nokey: assert property (p_nokey) else $error("nokey");
	property p_hold; o_chip_reset_request |=> o_chip_reset_request; endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule // esr_ctrl_assertions
bind esr_ctrl esr_ctrl_assertions i_chk (.*);
`default_nettype wire

// file: verif/esr_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module esr_core_model (
	input wire logic i_sys_clk,
	input wire logic [31:0] o_rdata,
	output logic [11:0] i_addr = 0,
	output logic [31:0] i_wdata = 0,
	output logic i_wr = 0,
	output logic i_rd = 0
);
	task automatic op(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r);
		i_addr <= a;
		i_wdata <= v & ~32'h2;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_sys_clk) {i_wr, i_rd} <= 2'b0;
		@(posedge i_sys_clk) r = o_rdata;
	endtask
endmodule // esr_core_model
`default_nettype wire

// file: verif/esr_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module esr_ctrl_test;
	logic i_sys_clk = 0, i_rst_b = 0, i_timer_event = 0, i_timer_taken = 0, i_preempt_on_halt_exit = 0;
	logic i_irq_pending_flag = 0, i_wr, i_rd, o_timer_pending, o_chip_reset_request, o_irq;
	logic [8:0] i_highest_pending_number = 0, i_active_exception_number = 0;
	logic [11:0] i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	int fail_count = 0, n_checks = 0;
	esr_ctrl i_dut (.*);
	esr_core_model i_cpu (.*);
	initial forever #2 i_sys_clk = ~i_sys_clk;
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic t_timer;
		i_cpu.op(1, 12'hd04, 32'h04000000, d);
		i_cpu.op(0, 12'hd04, 0, d);
		chk("set", d, 32'h04000000);
		i_cpu.op(1, 12'hd04, 0, d);
		chk("nop", o_timer_pending, 1);
		i_cpu.op(1, 12'hd04, 32'h02000000, d);
		chk("clr", o_timer_pending, 0);
	endtask
	task automatic t_status;
		{i_preempt_on_halt_exit, i_irq_pending_flag, i_highest_pending_number, i_active_exception_number} <= 20'hda0c3;
		i_cpu.op(0, 12'hd04, 0, d);
		chk("stat", d, 32'h00cd00c3);
	endtask
	task automatic t_irq;
		i_cpu.op(1, 12'hd48, 32'h1, d);
		i_timer_event <= 1;
		@(posedge i_sys_clk) i_timer_event <= 0;
		i_cpu.op(0, 12'hd40, 0, d);
		chk("irq", {d[0], o_irq}, 2'b11);
		i_cpu.op(1, 12'hd44, 32'h1, d);
		chk("irq", o_irq, 0);
		i_cpu.op(1, 12'hd48, 32'h0, d);
		i_timer_taken <= 1;
		@(posedge i_sys_clk) i_timer_taken <= 0;
		i_cpu.op(0, 12'h000, 0, d);
		chk("taken", o_timer_pending, 0);
		chk("mask", o_irq, 0);
		chk("unmapped", d, 0);
	endtask
	task automatic t_rst;
		i_cpu.op(1, 12'hd0c, 32'h00000004, d);
		chk("nokey", o_chip_reset_request, 0);
		i_cpu.op(1, 12'hd0c, 32'h05fa0004, d);
		i_cpu.op(0, 12'hd0c, 0, d);
		chk("app_interrupt_reset_control", d, 32'hfa050000);
		chk("req", o_chip_reset_request, 1);
		i_rst_b <= 0;
		@(posedge i_sys_clk) i_rst_b <= 1;
		@(posedge i_sys_clk) chk("req", o_chip_reset_request, 0);
	endtask
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_rst_b <= 1;
		@(posedge i_sys_clk);
		t_timer;
		t_status;
		t_irq;
		t_rst;
		report_and_stop;
	end
	initial begin
		#4000;
		fail_count++;
		report_and_stop;
	end
endmodule // esr_ctrl_test
`default_nettype wire
